// >>> inc/slu_pkg.sv
// Shared constants, types and helpers of the supply-line programming port
`default_nettype none

package slu_pkg;

	// =====================================================================
	// Timing
	// =====================================================================
	localparam int CLK_PERIOD_NS   = 20;                            // 50 MHz reference
	localparam int TBIT_NOM_NS     = 26000;                         // Nominal bit time
	localparam int BIT_CYC_NOM     = TBIT_NOM_NS / CLK_PERIOD_NS;   // Period used before sync
	localparam int CNT_W           = 20;                            // Bit and gap timer width
	localparam int SYNC_FALLS      = 4;                             // Falls after start edge in 0x55
	localparam int SYNC_SPAN_SHIFT = 3;                             // Those falls span 8 bits
	localparam int GAP_SHIFT       = 4;                             // Idle gap limit, in bits (log2)
	localparam int START_IDX       = 0;                             // Frame bit indices
	localparam int PAR_IDX         = 9;
	localparam int STOP_IDX        = 10;

	// =====================================================================
	// Register map
	// =====================================================================
	localparam int          ADDR_W          = 7;
	localparam int          REG_DEPTH       = 128;
	localparam int          RW_BIT          = 7;      // Set in address frame for a read
	localparam logic [6:0]  ADDR_CTRL       = 7'h23;
	localparam logic [6:0]  ADDR_ANGLE_LO   = 7'h32;
	localparam logic [6:0]  ADDR_ANGLE_HI   = 7'h33;
	localparam logic [6:0]  ADDR_MAG        = 7'h34;
	localparam logic [6:0]  ADDR_AGC        = 7'h35;
	localparam logic [6:0]  ADDR_EXIT_LO    = 7'h60;  // mode_exit_key_low
	localparam logic [6:0]  ADDR_EXIT_HI    = 7'h61;  // mode_exit_key_high
	localparam logic [6:0]  ADDR_BURN_LO    = 7'h62;  // fuse_burn_key_low
	localparam logic [6:0]  ADDR_BURN_HI    = 7'h63;  // fuse_burn_key_high
	localparam logic [7:0]  KEY_LO_VAL      = 8'h70;
	localparam logic [7:0]  KEY_HI_VAL      = 8'h51;
	localparam int          CTRL_HOLD_BIT   = 5;
	localparam int          CTRL_CHK_BIT    = 6;
	localparam int          ANGLE_W         = 14;

	// Transfer parameters, flat over bytes 0x14..0x1d
	localparam logic [6:0]  ADDR_PARAM_BASE = 7'h14;
	localparam int          PARAM_BYTES     = 10;
	localparam int          CLH_LSB         = 0;
	localparam int          CLL_LSB         = 12;
	localparam int          CL_W            = 12;
	localparam int          OFS_LSB         = 24;
	localparam int          OFS_W           = 20;
	localparam int          GAIN_LSB        = 44;
	localparam int          GAIN_W          = 17;
	localparam int          BP_LSB          = 61;
	localparam int          GAIN_SHIFT      = 12;

	// Output protocol versions
	localparam int          RES_V1          = 10;
	localparam int          RES_V2          = 12;
	localparam int          OUT_W           = 13;
	localparam int          XF_W            = 21;
	localparam logic signed [20:0] OUT_LIM_V1 = 21'sd480;
	localparam logic signed [20:0] OUT_LIM_V2 = 21'sd2048;

	// =====================================================================
	// Types
	// =====================================================================
	typedef enum logic [3:0] {
		SEQ_SYNC, SEQ_MEAS, SEQ_TAIL, SEQ_ADDR, SEQ_WR0,
		SEQ_WR1, SEQ_RD0, SEQ_RD1, SEQ_BURN, SEQ_FUNC
	} slu_seq_e;

	// Saturate a value into [lo, hi]
	function automatic logic signed [20:0] slu_clamp(input logic signed [20:0] v,
		input logic signed [20:0] lo, input logic signed [20:0] hi);
		logic signed [20:0] r;
		r = v;
		if (v > hi) begin
			r = hi;
		end
		if (v < lo) begin
			r = lo;
		end
		return r;
	endfunction : slu_clamp

endpackage : slu_pkg

`default_nettype wire

// >>> hw/slu_regmem.sv
// Byte-wide register memory with a registered read port
`timescale 1ns/100ps
`default_nettype none

module slu_regmem
	import slu_pkg::*;
(
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_b_i,
	input  wire logic                        we_i,
	input  wire logic [slu_pkg::ADDR_W-1:0] waddr_i,
	input  wire logic [7:0]                  wdata_i,
	input  wire logic [slu_pkg::ADDR_W-1:0] raddr_i,
	output logic      [7:0]                  rdata_o
);

	// =====================================================================
	// Storage
	// =====================================================================
	logic [7:0] mem [0:REG_DEPTH-1];

	// Array carries no reset so it maps onto plain RAM cells
	always_ff @(posedge ref_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Read data always leaves through a flop
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule : slu_regmem

`default_nettype wire

// >>> hw/slu_uart_tx.sv
// Answer frame sender driving the supply current sink
`timescale 1ns/100ps
`default_nettype none

module slu_uart_tx
	import slu_pkg::*;
(
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_b_i,
	input  wire logic                       start_i,
	input  wire logic [7:0]                 byte_i,
	input  wire logic [slu_pkg::CNT_W-1:0] per_i,
	output logic                            sink_o,
	output logic                            done_o
);

	typedef struct packed {
		logic             act;
		logic [3:0]       idx;
		logic [CNT_W-1:0] tmr;
		logic [10:0]      shf;
		logic             sink;
		logic             done;
	} slu_tx_s;

	slu_tx_s q;
	slu_tx_s n;

	// =====================================================================
	// Frame shifter
	// =====================================================================
	// A zero bit is sent as increased sink current, a one as idle current
	always_comb begin
		n      = q;
		n.done = 1'b0;
		if (!q.act) begin
			if (start_i) begin
				n.act  = 1'b1;
				n.idx  = 4'h0;
				n.tmr  = per_i - CNT_W'(1);
				n.shf  = {1'b1, ^byte_i, byte_i, 1'b0};
				n.sink = 1'b1;
			end
		end else if (q.tmr == '0) begin
			if (q.idx == 4'(STOP_IDX)) begin
				n.act  = 1'b0;
				n.sink = 1'b0;
				n.done = 1'b1;
			end else begin
				n.idx  = q.idx + 4'h1;
				n.shf  = q.shf >> 1;
				n.sink = ~q.shf[1];
				n.tmr  = per_i - CNT_W'(1);
			end
		end else begin
			n.tmr = q.tmr - CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign sink_o = q.sink;
	assign done_o = q.done;

endmodule : slu_uart_tx

`default_nettype wire

// >>> hw/slu_port.sv
// Supply-line programming port: frame receiver, register access and mode control
`timescale 1ns/100ps
`default_nettype none

// Function
// - Start up in communication mode after reset
// - Answer zero as increased sink current
// - Access is four frames, two consecutive registers
// - Frame is start, eight data, parity, stop
// - Even parity over data, checked on receive
// - Data bits travel least significant first
// - First frame 0x55 locks bit timing
// - Second frame holds address and direction
// - Third and fourth frames carry data
// - Hold bit resets processor, refreshes readbacks
// - Exit key pair enters functional mode
// - Exit-key functional mode ends at reset
// - Burn key pair starts fuse burning
// - Locked or exited device runs output protocol
// - Resolution ten or twelve bits per version
// - Output limits per protocol version
// - Output linear in angle around breakpoint
// - Transfer set by clamps, offset, gain, breakpoint
// - Hold control is bit five of 0x23
// - Raw angle fourteen bits at 0x32/0x33
module slu_port
	import slu_pkg::*;
#(
	parameter int BURN_CYCLES = 100000
)
(
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_b_i,
	input  wire logic                          supply_hi_i,
	input  wire logic [slu_pkg::ANGLE_W-1:0]  raw_angle_i,
	input  wire logic [7:0]                    magnitude_i,
	input  wire logic [7:0]                    agc_i,
	input  wire logic                          fuse_lock_i,
	input  wire logic                          proto_v2_i,
	output logic                               sink_en_o,
	output logic                               comm_mode_o,
	output logic                               func_mode_o,
	output logic                               dsp_hold_o,
	output logic                               fuse_check_o,
	output logic                               burn_start_o,
	output logic                               burn_busy_o,
	output logic      [slu_pkg::OUT_W-1:0]    out_code_o
);

	import slu_pkg::*;

	// =====================================================================
	// State
	// =====================================================================
	typedef struct packed {
		logic                   line_m;      // Pin synchroniser, first stage
		logic                   line_s;      // Pin synchroniser, second stage
		logic                   line_d;      // Previous synchronised level
		slu_seq_e               st;
		logic                   rx_act;
		logic [3:0]             bit_idx;
		logic [CNT_W-1:0]       tmr;
		logic [CNT_W-1:0]       per;
		logic [2:0]             falls;
		logic [8:0]             shf;
		logic [ADDR_W-1:0]      addr;
		logic [7:0]             d0;
		logic                   rd_pend;
		logic                   hold;
		logic                   chk;
		logic [ANGLE_W-1:0]     snap_angle;
		logic [7:0]             snap_mag;
		logic [7:0]             snap_agc;
		logic                   exit_key;
		logic                   func;
		logic                   comm;
		logic                   burn_start;
		logic                   burn_busy;
		logic                   tx_start;
		logic [7:0]             tx_byte;
		logic [8*PARAM_BYTES-1:0] shadow;
		logic [OUT_W-1:0]       out_code;
	} slu_port_s;

	slu_port_s q;
	slu_port_s n;

	logic                   rx_bit;
	logic                   frame_ok;
	logic                   frame_err;
	logic [7:0]             rx_byte;
	logic [ADDR_W-1:0]      cur_addr;
	logic [ADDR_W-1:0]      pidx;
	logic                   mem_we;
	logic [ADDR_W-1:0]      mem_raddr;
	logic [7:0]             mem_rdata;
	logic                   tx_done;
	logic                   tx_sink;
	logic signed [14:0]     xf_diff;
	logic signed [32:0]     xf_prod;
	logic signed [XF_W-1:0] xf_lin;
	logic signed [XF_W-1:0] xf_clp;
	logic signed [XF_W-1:0] xf_res;
	logic signed [XF_W-1:0] xf_lim;

	// =====================================================================
	// Read data selection
	// =====================================================================
	// Live registers override the memory copy; key registers read as zero
	function automatic logic [7:0] rd_sel(input logic [ADDR_W-1:0] a,
		input logic [7:0] mem_d, input logic hold, input logic chk,
		input logic [ANGLE_W-1:0] ang, input logic [7:0] mag, input logic [7:0] agc);
		logic [7:0] r;
		r = mem_d;
		unique case (a)
			ADDR_CTRL: begin
				r = 8'h00;
				r[CTRL_HOLD_BIT] = hold;
				r[CTRL_CHK_BIT]  = chk;
			end
			ADDR_ANGLE_LO: begin
				r = ang[7:0];
			end
			ADDR_ANGLE_HI: begin
				r = {2'b00, ang[ANGLE_W-1:8]};
			end
			ADDR_MAG: begin
				r = mag;
			end
			ADDR_AGC: begin
				r = agc;
			end
			ADDR_EXIT_LO, ADDR_EXIT_HI, ADDR_BURN_LO, ADDR_BURN_HI: begin
				r = 8'h00;
			end
			default: begin
				r = mem_d;
			end
		endcase
		return r;
	endfunction : rd_sel

	// =====================================================================
	// Next-state logic
	// =====================================================================
	always_comb begin
		n            = q;
		n.line_m     = supply_hi_i;
		n.line_s     = q.line_m;
		n.line_d     = q.line_s;
		n.burn_start = 1'b0;
		n.tx_start   = 1'b0;
		rx_bit       = ~q.line_s;
		rx_byte      = q.shf[7:0];
		frame_ok     = 1'b0;
		frame_err    = 1'b0;
		mem_we       = 1'b0;
		mem_raddr    = q.addr;
		cur_addr     = (q.st == SEQ_WR1 || q.st == SEQ_RD1) ? q.addr + 7'h01 : q.addr;
		pidx         = cur_addr - ADDR_PARAM_BASE;

		// Frame receiver; runs only while a frame from the programmer is due
		if (q.st == SEQ_ADDR || q.st == SEQ_WR0 || q.st == SEQ_WR1) begin
			if (!q.rx_act) begin
				if (!rx_bit) begin
					n.rx_act  = 1'b1;
					n.bit_idx = 4'h0;
					n.tmr     = q.per >> 1;
				end else begin
					n.tmr = q.tmr + CNT_W'(1);
					// A stalled access falls back to waiting for a new sync frame
					if (q.tmr >= (q.per << GAP_SHIFT)) begin
						n.st = SEQ_SYNC;
					end
				end
			end else if (q.tmr == '0) begin
				n.tmr     = q.per - CNT_W'(1);
				n.bit_idx = q.bit_idx + 4'h1;
				if (q.bit_idx == 4'(START_IDX)) begin
					// Start bit gone at mid-period: glitch, rearm quietly
					if (rx_bit) begin
						n.rx_act = 1'b0;
						n.tmr    = '0;
					end
				end else if (q.bit_idx <= 4'(PAR_IDX)) begin
					n.shf = {rx_bit, q.shf[8:1]};
				end else begin
					n.rx_act = 1'b0;
					n.tmr    = '0;
					if (rx_bit && !(^q.shf)) begin
						frame_ok = 1'b1;
					end else begin
						frame_err = 1'b1;
					end
				end
			end else begin
				n.tmr = q.tmr - CNT_W'(1);
			end
		end

		// Access sequencer
		unique case (q.st)
			SEQ_SYNC: begin
				n.tmr   = '0;
				n.falls = 3'h0;
				if (!rx_bit) begin
					n.st = SEQ_MEAS;
				end
			end
			SEQ_MEAS: begin
				n.tmr = q.tmr + CNT_W'(1);
				if (&q.tmr) begin
					n.st = SEQ_SYNC;
				end else if (!q.line_d && q.line_s) begin
					n.falls = q.falls + 3'h1;
					// Fourth fall after the start edge is eight bit times later
					if (q.falls == 3'(SYNC_FALLS - 1)) begin
						n.per = (q.tmr + CNT_W'(1)) >> SYNC_SPAN_SHIFT;
						n.st  = SEQ_TAIL;
					end
				end
			end
			SEQ_TAIL: begin
				if (rx_bit) begin
					n.st     = SEQ_ADDR;
					n.rx_act = 1'b0;
					n.tmr    = '0;
				end
			end
			SEQ_ADDR: begin
				if (frame_ok) begin
					n.addr = rx_byte[ADDR_W-1:0];
					if (rx_byte[RW_BIT]) begin
						n.st      = SEQ_RD0;
						n.rd_pend = 1'b1;
						mem_raddr = rx_byte[ADDR_W-1:0];
					end else begin
						n.st = SEQ_WR0;
					end
				end
			end
			SEQ_WR0, SEQ_WR1: begin
				if (frame_ok) begin
					mem_we = 1'b1;
					if (cur_addr == ADDR_CTRL) begin
						n.hold = rx_byte[CTRL_HOLD_BIT];
						n.chk  = rx_byte[CTRL_CHK_BIT];
					end
					if (pidx < 7'(PARAM_BYTES)) begin
						n.shadow[8*pidx +: 8] = rx_byte;
					end
					if (q.st == SEQ_WR0) begin
						n.d0 = rx_byte;
						n.st = SEQ_WR1;
					end else begin
						n.st = SEQ_SYNC;
						if (q.addr == ADDR_EXIT_LO && q.d0 == KEY_LO_VAL && rx_byte == KEY_HI_VAL) begin
							n.exit_key = 1'b1;
							n.st       = SEQ_FUNC;
						end
						if (q.addr == ADDR_BURN_LO && q.d0 == KEY_LO_VAL && rx_byte == KEY_HI_VAL) begin
							n.burn_start = 1'b1;
							n.burn_busy  = 1'b1;
							n.tmr        = '0;
							n.st         = SEQ_BURN;
						end
					end
				end
			end
			SEQ_RD0, SEQ_RD1: begin
				// Memory answers one cycle after the address, so load then send
				if (q.rd_pend) begin
					n.rd_pend  = 1'b0;
					n.tx_start = 1'b1;
					n.tx_byte  = rd_sel(cur_addr, mem_rdata, q.hold, q.chk,
						q.snap_angle, q.snap_mag, q.snap_agc);
				end else if (tx_done) begin
					if (q.st == SEQ_RD0) begin
						mem_raddr = q.addr + 7'h01;
						n.rd_pend = 1'b1;
						n.st      = SEQ_RD1;
					end else begin
						n.st = SEQ_SYNC;
					end
				end
			end
			SEQ_BURN: begin
				// Port is deaf until the fuse sequence has run its course
				n.tmr = q.tmr + CNT_W'(1);
				if (q.tmr == CNT_W'(BURN_CYCLES - 1)) begin
					n.burn_busy = 1'b0;
					n.st        = SEQ_SYNC;
				end
			end
			SEQ_FUNC: begin
				n.st = SEQ_FUNC;
			end
		endcase

		// Any damaged frame abandons the rest of the access; bytes already written stay
		if (frame_err) begin
			n.st = SEQ_SYNC;
		end

		// A burned lock fuse raises functional mode at once and moves the sequencer to SEQ_FUNC once no burn is running
		if (fuse_lock_i && n.st != SEQ_BURN) begin
			n.st = SEQ_FUNC;
		end
		n.func = n.exit_key | fuse_lock_i;
		n.comm = ~n.func;

		// Entering processor reset refreshes the readback copies
		if (n.hold && !q.hold) begin
			n.snap_angle = raw_angle_i;
			n.snap_mag   = magnitude_i;
			n.snap_agc   = agc_i;
		end

		// Transfer function: linear about the breakpoint, clamped twice
		xf_diff = 15'($signed({1'b0, raw_angle_i}) - $signed({1'b0, q.shadow[BP_LSB +: ANGLE_W]}));
		xf_prod = 33'(xf_diff) * 33'($signed({1'b0, q.shadow[GAIN_LSB +: GAIN_W]}));
		xf_lin  = XF_W'(xf_prod >>> GAIN_SHIFT) + XF_W'($signed(q.shadow[OFS_LSB +: OFS_W]));
		xf_clp  = slu_clamp(xf_lin, XF_W'($signed(q.shadow[CLL_LSB +: CL_W])),
			XF_W'($signed(q.shadow[CLH_LSB +: CL_W])));
		xf_res  = proto_v2_i ? xf_clp : (xf_clp >>> (RES_V2 - RES_V1));
		xf_lim  = proto_v2_i ? OUT_LIM_V2 : OUT_LIM_V1;
		if (q.func) begin
			n.out_code = OUT_W'(slu_clamp(xf_res, -xf_lim, xf_lim));
		end
	end

	// =====================================================================
	// State register
	// =====================================================================
	// Exit key lives only here, so any reset returns to communication mode unless the lock fuse is burned
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q        <= '0;
			q.line_m <= 1'b0;
			q.line_s <= 1'b0;
			q.line_d <= 1'b0;
			q.comm   <= 1'b1;
			q.per    <= CNT_W'(BIT_CYC_NOM);
		end else begin
			q <= n;
		end
	end

	// =====================================================================
	// Register memory and answer sender
	// =====================================================================
	slu_regmem u_regmem (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.we_i      (mem_we),
		.waddr_i   (cur_addr),
		.wdata_i   (rx_byte),
		.raddr_i   (mem_raddr),
		.rdata_o   (mem_rdata)
	);

	slu_uart_tx u_tx (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.start_i   (q.tx_start),
		.byte_i    (q.tx_byte),
		.per_i     (q.per),
		.sink_o    (tx_sink),
		.done_o    (tx_done)
	);

	// =====================================================================
	// Outputs
	// =====================================================================
	assign sink_en_o    = tx_sink;                      // Flop inside the sender
	assign comm_mode_o  = q.comm;
	assign func_mode_o  = q.func;
	assign dsp_hold_o   = q.hold;
	assign fuse_check_o = q.chk;
	assign burn_start_o = q.burn_start;
	assign burn_busy_o  = q.burn_busy;
	assign out_code_o   = q.out_code;

endmodule : slu_port

`default_nettype wire

// >>> verif/slu_port_chk.sv
// Assertion checker for the supply-line programming port
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Checker
// =====================================================================
module slu_port_chk #(
	parameter int BURN_CYCLES = 100000
)(
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_b_i,
	input  wire logic                       fuse_lock_i,
	input  wire logic                       proto_v2_i,
	input  wire logic                       sink_en_o,
	input  wire logic                       comm_mode_o,
	input  wire logic                       func_mode_o,
	input  wire logic                       burn_start_o,
	input  wire logic                       burn_busy_o,
	input  wire logic [slu_pkg::OUT_W-1:0] out_code_o
);
	logic [31:0] busy_cnt_reg;

	// Burn length is far beyond a repetition count, so count it here
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_cnt_reg <= 32'h0;
		end else begin
			busy_cnt_reg <= burn_busy_o ? busy_cnt_reg + 32'h1 : 32'h0;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_modes_excl: assert property (comm_mode_o != func_mode_o)
		else $error("mode flags not exclusive");
	a_func_sticky: assert property (func_mode_o |=> func_mode_o)
		else $error("functional mode left without reset");
	a_lock_func: assert property (fuse_lock_i && !burn_busy_o |-> ##[1:2] func_mode_o)
		else $error("lock fuse did not force functional mode");
	a_burn_pulse: assert property (burn_start_o |=> !burn_start_o)
		else $error("burn start longer than one cycle");
	a_burn_busy: assert property (burn_start_o |-> ##[0:1] burn_busy_o)
		else $error("burn busy missing after start");
	a_burn_len: assert property ($fell(burn_busy_o) |-> busy_cnt_reg == BURN_CYCLES)
		else $error("burn busy length wrong");
	a_burn_quiet: assert property (burn_busy_o |-> !sink_en_o)
		else $error("answer sent during burn");
	a_out_frozen: assert property (!func_mode_o ##1 !func_mode_o |-> $stable(out_code_o))
		else $error("output code moved outside functional mode");
	a_out_lim: assert property (func_mode_o && $stable(proto_v2_i) |-> (proto_v2_i ?
		($signed(out_code_o) <= 2048 && $signed(out_code_o) >= -2048) :
		($signed(out_code_o) <= 480 && $signed(out_code_o) >= -480)))
		else $error("output code beyond limits");
endmodule : slu_port_chk

bind slu_port slu_port_chk #(.BURN_CYCLES(BURN_CYCLES)) u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
	.fuse_lock_i(fuse_lock_i), .proto_v2_i(proto_v2_i), .sink_en_o(sink_en_o), .comm_mode_o(comm_mode_o),
	.func_mode_o(func_mode_o), .burn_start_o(burn_start_o), .burn_busy_o(burn_busy_o), .out_code_o(out_code_o));

`default_nettype wire

// >>> verif/slu_prog_model.sv
// Behavioural programmer driving the supply level and reading the sink current
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Programmer model
// =====================================================================
module slu_prog_model #(
	parameter int P = 32
)(
	input  wire logic ref_clk_i,
	input  wire logic sink_en_i,
	output var  logic supply_hi_o
);
	int   gap      = 0;
	logic flip_par = 1'b0;  // Set to send a frame with broken parity

	// Idle at the low supply level, which reads as logic 1
	initial supply_hi_o = 1'b0;

	// One frame; an idle gap first lets the bench act as a slow programmer
	task automatic send_byte(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, ^b ^ flip_par, b, 1'b0};
		repeat (gap) @(posedge ref_clk_i);
		for (int k = 0; k < 11; k++) begin
			supply_hi_o <= ~f[k];
			repeat (P) @(posedge ref_clk_i);
		end
	endtask : send_byte

	// Mid-bit sampling; a broken frame returns unknown so no compare can pass
	task automatic recv_byte(output logic [7:0] b);
		logic [10:0] f;
		int          i;
		i = 0;
		while (sink_en_i !== 1'b1 && i < 40 * P) begin
			@(posedge ref_clk_i);
			i++;
		end
		repeat (P / 2) @(posedge ref_clk_i);
		for (int k = 0; k < 11; k++) begin
			f[k] = ~sink_en_i;
			if (k < 10) begin
				repeat (P) @(posedge ref_clk_i);
			end
		end
		b = (f[0] === 1'b0 && f[10] === 1'b1 && ^f[9:1] === 1'b0) ? f[8:1] : 8'hxx;
	endtask : recv_byte
endmodule : slu_prog_model

`default_nettype wire

// >>> verif/slu_port_tb.sv
// Self-checking testbench of the supply-line programming port
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Testbench
// =====================================================================
module slu_port_tb;
	import slu_pkg::*;
	localparam int P = 32;
	logic               ref_clk_i = 1'b0;
	logic               rst_b_i   = 1'b0;
	logic               supply_hi;
	logic [ANGLE_W-1:0] raw_angle = 14'h2b6d;
	logic [7:0]         mag       = 8'h9c;
	logic [7:0]         agc       = 8'h47;
	logic               fuse_lock = 1'b0;
	logic               proto_v2  = 1'b0;
	logic               sink_en, comm, func, hold, fchk, bstart, busy;
	logic [OUT_W-1:0]   out_code;
	int                 n_fail      = 0;
	int                 check_count = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	slu_port #(.BURN_CYCLES(50)) uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .supply_hi_i(supply_hi),
		.raw_angle_i(raw_angle), .magnitude_i(mag), .agc_i(agc), .fuse_lock_i(fuse_lock),
		.proto_v2_i(proto_v2), .sink_en_o(sink_en), .comm_mode_o(comm), .func_mode_o(func),
		.dsp_hold_o(hold), .fuse_check_o(fchk), .burn_start_o(bstart), .burn_busy_o(busy),
		.out_code_o(out_code));

	slu_prog_model #(.P(P)) prog (.ref_clk_i(ref_clk_i), .sink_en_i(sink_en), .supply_hi_o(supply_hi));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_code(input logic [OUT_W-1:0] got, input logic [OUT_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_code

	task automatic stop_test();
		if (n_fail == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	// Four-frame accesses, always opened by a fresh sync frame
	task automatic wr(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1);
		prog.send_byte(8'h55);
		prog.send_byte({1'b0, a});
		prog.send_byte(d0);
		prog.send_byte(d1);
		repeat (4) @(posedge ref_clk_i);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [7:0] e0, input logic [7:0] e1);
		logic [7:0] r0, r1;
		prog.send_byte(8'h55);
		fork
			prog.send_byte({1'b1, a});
			begin
				prog.recv_byte(r0);
				prog.recv_byte(r1);
			end
		join
		repeat (P) @(posedge ref_clk_i);
		chk(r0, e0);
		chk(r1, e1);
	endtask : rd

	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk({6'h0, comm, func}, 8'h02);
		// Clamps at +2047/-2048 and a large offset drive the output into its limit
		wr(7'h14, 8'hff, 8'h07);
		wr(7'h16, 8'h80, 8'hff);
		wr(7'h18, 8'hff, 8'h07);
		wr(7'h1a, 8'h00, 8'h00);
		wr(7'h1c, 8'h00, 8'h00);
		prog.gap = 2 * P;
		wr(7'h40, 8'ha5, 8'h3c);
		prog.gap = 0;
		rd(7'h40, 8'ha5, 8'h3c);
		// Bad parity on the last frame drops it; the first byte already landed
		prog.send_byte(8'h55);
		prog.send_byte(8'h40);
		prog.send_byte(8'h11);
		prog.flip_par = 1'b1;
		prog.send_byte(8'h22);
		prog.flip_par = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		rd(7'h40, 8'h11, 8'h3c);
		wr(7'h23, 8'h20, 8'h00);
		raw_angle <= 14'h1111;
		mag <= 8'h00;
		agc <= 8'h00;
		chk({7'h0, hold}, 8'h01);
		rd(7'h32, 8'h6d, 8'h2b);
		rd(7'h34, 8'h9c, 8'h47);
		wr(7'h62, 8'h70, 8'h51);
		chk({7'h0, busy}, 8'h01);
		repeat (60) @(posedge ref_clk_i);
		chk({7'h0, busy}, 8'h00);
		wr(7'h23, 8'h40, 8'h00);
		rd(7'h23, 8'h40, 8'h00);
		chk({6'h0, hold, fchk}, 8'h01);
		rd(7'h62, 8'h00, 8'h00);
		wr(7'h60, 8'h70, 8'h51);
		chk({6'h0, comm, func}, 8'h01);
		chk_code(out_code, OUT_W'(OUT_LIM_V1));
		repeat (200) @(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		proto_v2 <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk({6'h0, comm, func}, 8'h02);
		fuse_lock <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk({6'h0, comm, func}, 8'h01);
		repeat (200) @(posedge ref_clk_i);
		stop_test();
	end

	// Watchdog: the whole sequence needs about two fifths of this span
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		n_fail++;
		stop_test();
	end
endmodule : slu_port_tb

`default_nettype wire
